// File: core/pcd_controller.sv
/*
  Clock divider controller top: mode routing, pre-divider, loop multiplier
  model, sixteen system dividers, apply (GO) sequencer and status.
  Assumes reference_clock_in is asynchronous and much slower than sys_clk;
  control bits are written by the CPU only.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - loop multiplier factor one to four on pre-divided reference.
// - pre-divider and system dividers divide 1..32, each can be disabled.
// - disabled divider outputs no clock.
// - while source bit set, mode bit stored but ignored.
// - mode 1 routes via pre-divider and loop; 0 bypasses both.
// - mode bit resets to 0, bypass.
// - loop mode: reference divided by pre-divider, multiplied, fed to dividers.
// - enabled divider divides by applied ratio, 50% duty; in loop mode the burst loop ticks give uneven duty.
// - ratio writes only stored until apply operation.
// - writing 1 to apply trigger starts apply operation.
// - aligned changed clocks held low, restart together on rising edge.
// - changed unaligned clocks switch ratio immediately.
// - apply busy set during whole apply operation.
// - loop reset bit 1 holds loop in reset, 0 releases.
// - auxiliary output is reference clock unmodified.
// - sixteen system clock outputs, each with own divider.
// - ratio write to different value sets ratio changed bit.
// - apply busy returns to 0 at end of apply.
module pcd_controller
  import pcd_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         srst,
  input  wire logic                         reference_clock_in,
  input  wire logic                         loop_mode_select,
  input  wire logic                         mode_select_source,
  input  wire logic                         loop_reset_ctl,
  input  wire logic [pcd_pkg::MULT_W-1:0]   loop_multiplier,
  input  wire logic [pcd_pkg::RATIO_W-1:0]  pre_divider,
  input  wire logic                         pre_divider_enable,
  input  wire logic [pcd_pkg::NUM_SYS-1:0]  div_wr,
  input  wire logic [pcd_pkg::RATIO_W-1:0]  div_wr_ratio,
  input  wire logic [pcd_pkg::NUM_SYS-1:0]  system_divider_enable,
  input  wire logic [pcd_pkg::NUM_SYS-1:0]  align_select_reg,
  input  wire logic                         apply_trigger,
  output logic                              apply_busy,
  output logic [pcd_pkg::NUM_SYS-1:0]       ratio_changed_reg,
  output logic                              loop_in_reset,
  output logic                              mode_effective,
  output logic                              auxiliary_clock_out,
  output logic [pcd_pkg::NUM_SYS-1:0]       system_clock_out
);
  import pcd_pkg::*;

  // Reference synchroniser, three stages
  logic [2:0] ref_sync_reg, ref_sync_next;
  logic       ref_lvl_reg, ref_lvl_next;
  logic       ref_tick;
  logic       ref_edge;

  // Control state
  logic                  mode_reg, mode_next;
  logic                  lrst_reg, lrst_next;
  logic                  aux_reg, aux_next;
  logic [RATIO_W-1:0]    pre_cnt_reg, pre_cnt_next;
  logic [2:0]            mul_cnt_reg, mul_cnt_next;
  logic                  pre_tick, loop_tick, div_tick;
  logic [RATIO_W-1:0]    ratio_reg [NUM_SYS];
  logic [RATIO_W-1:0]    ratio_next [NUM_SYS];
  logic [NUM_SYS-1:0]    chg_reg, chg_next;
  logic [NUM_SYS-1:0]    applied_reg, applied_next;
  pcd_state_t            state_reg, state_next;
  logic [5:0]            hold_cnt_reg, hold_cnt_next;
  logic                  busy_reg, busy_next;
  logic [NUM_SYS-1:0]    hold_mask, load_mask, div_out;

  always_comb
  begin
    ref_sync_next = {ref_sync_reg[1:0], reference_clock_in};
    ref_lvl_next  = ref_lvl_reg;
    if (ref_sync_reg[1] == ref_sync_reg[2])
      ref_lvl_next = ref_sync_reg[2];
    ref_tick = ref_lvl_next && !ref_lvl_reg;
    ref_edge = ref_lvl_next != ref_lvl_reg;
    aux_next = ref_lvl_next;
  end

  // Mode routing and loop model
  always_comb
  begin
    mode_next   = mode_reg;
    lrst_next   = loop_reset_ctl;
    pre_cnt_next = pre_cnt_reg;
    mul_cnt_next = mul_cnt_reg;
    pre_tick    = 1'b0;
    if (!mode_select_source)
      mode_next = loop_mode_select;
    if (ref_tick && pre_divider_enable)
    begin
      if (pre_cnt_reg >= pre_divider)
      begin
        pre_cnt_next = '0;
        pre_tick     = 1'b1;
      end
      else
        pre_cnt_next = pre_cnt_reg + 5'h01;
    end
    // Loop clock emitted as edge ticks on sys_clk, two per multiplied period
    loop_tick = 1'b0;
    if (lrst_reg)
      mul_cnt_next = 3'h0;
    else if (pre_tick)
    begin
      mul_cnt_next = {loop_multiplier, 1'b1};
      loop_tick    = 1'b1;
    end
    else if (mul_cnt_reg != 3'h0)
    begin
      mul_cnt_next = mul_cnt_reg - 3'h1;
      loop_tick    = 1'b1;
    end
    // Bypass feeds the reference straight in
    div_tick = mode_reg ? loop_tick : ref_edge;
  end

  // Ratio storage and change flags
  always_comb
  begin
    chg_next = chg_reg;
    for (int i = 0; i < NUM_SYS; i++)
    begin
      ratio_next[i] = ratio_reg[i];
      if (div_wr[i])
        ratio_next[i] = div_wr_ratio;
    end
    // Clear first so a new change in the same cycle wins
    if (state_reg == PCD_DONE)
      chg_next = chg_reg & ~applied_reg;
    for (int i = 0; i < NUM_SYS; i++)
      if (div_wr[i] && div_wr_ratio != ratio_reg[i])
        chg_next[i] = 1'b1;
  end

  // Apply sequencer
  always_comb
  begin
    state_next    = state_reg;
    hold_cnt_next = hold_cnt_reg;
    busy_next     = busy_reg;
    applied_next  = applied_reg;
    hold_mask     = '0;
    load_mask     = '0;
    case (state_reg)
      PCD_IDLE:
      begin
        if (apply_trigger)
        begin
          state_next   = PCD_APPLY;
          busy_next    = 1'b1;
          applied_next = chg_reg;
        end
      end
      PCD_APPLY:
      begin
        load_mask     = applied_reg & ~align_select_reg;
        hold_mask     = applied_reg & align_select_reg;
        hold_cnt_next = HOLD_CYCLES;
        state_next    = PCD_HOLD;
      end
      PCD_HOLD:
      begin
        hold_mask = applied_reg & align_select_reg;
        if (hold_cnt_reg == 6'h00)
        begin
          load_mask  = applied_reg & align_select_reg;
          state_next = PCD_DONE;
        end
        else
          hold_cnt_next = hold_cnt_reg - 6'h01;
      end
      PCD_DONE:
      begin
        busy_next  = 1'b0;
        state_next = PCD_IDLE;
      end
      default:
        state_next = PCD_IDLE;
    endcase
  end

  for (genvar g = 0; g < NUM_SYS; g++)
  begin : g_div
    pcd_divider u_div (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .ref_tick (div_tick),
      .enable   (system_divider_enable[g]),
      .hold     (hold_mask[g]),
      .load_now (load_mask[g]),
      .ratio    (ratio_reg[g]),
      .clk_out  (div_out[g])
    );
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ref_sync_reg <= 3'h0;
      ref_lvl_reg  <= 1'b0;
      aux_reg      <= 1'b0;
      mode_reg     <= MODE_RST;
      lrst_reg     <= LRST_RST;
      pre_cnt_reg  <= '0;
      mul_cnt_reg  <= 3'h0;
      chg_reg      <= '0;
      applied_reg  <= '0;
      state_reg    <= PCD_IDLE;
      hold_cnt_reg <= 6'h00;
      busy_reg     <= 1'b0;
      for (int i = 0; i < NUM_SYS; i++)
        ratio_reg[i] <= RATIO_RST;
    end
    else
    begin
      ref_sync_reg <= ref_sync_next;
      ref_lvl_reg  <= ref_lvl_next;
      aux_reg      <= aux_next;
      mode_reg     <= mode_next;
      lrst_reg     <= lrst_next;
      pre_cnt_reg  <= pre_cnt_next;
      mul_cnt_reg  <= mul_cnt_next;
      chg_reg      <= chg_next;
      applied_reg  <= applied_next;
      state_reg    <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      busy_reg     <= busy_next;
      for (int i = 0; i < NUM_SYS; i++)
        ratio_reg[i] <= ratio_next[i];
    end
  end

  assign apply_busy          = busy_reg;
  assign ratio_changed_reg   = chg_reg;
  assign loop_in_reset       = lrst_reg;
  assign mode_effective      = mode_reg;
  assign auxiliary_clock_out = aux_reg;
  assign system_clock_out    = div_out;

  property p_src_blocks;
    @(posedge sys_clk) disable iff (srst)
      mode_select_source |=> $stable(mode_effective);
  endproperty
  a_src_blocks: assert property (p_src_blocks) else $error("mode changed while source set");

  property p_start;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == PCD_IDLE && apply_trigger) |=> apply_busy;
  endproperty
  a_start: assert property (p_start) else $error("apply did not start");

  property p_busy_end;
    @(posedge sys_clk) disable iff (srst)
      $rose(apply_busy) |-> ##[34:36] !apply_busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy length wrong");

  property p_busy_hold;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == PCD_HOLD) |-> apply_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped during apply");

  property p_chg_set;
    @(posedge sys_clk) disable iff (srst)
      (div_wr[3] && div_wr_ratio != ratio_reg[3]) |=> ratio_changed_reg[3];
  endproperty
  a_chg_set: assert property (p_chg_set) else $error("change flag not set");

  property p_held_low;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == PCD_HOLD) |-> (system_clock_out & hold_mask) == '0;
  endproperty
  a_held_low: assert property (p_held_low) else $error("aligned clock not held");

  property p_aux;
    @(posedge sys_clk) disable iff (srst)
      $changed(ref_lvl_reg) |=> auxiliary_clock_out == $past(ref_lvl_reg);
  endproperty
  a_aux: assert property (p_aux) else $error("aux not following reference");

  property p_lrst;
    @(posedge sys_clk) disable iff (srst) loop_reset_ctl |=> loop_in_reset;
  endproperty
  a_lrst: assert property (p_lrst) else $error("loop not held in reset");

  property p_ratio_stored;
    @(posedge sys_clk) disable iff (srst) div_wr[6] |=> ratio_reg[6] == $past(div_wr_ratio);
  endproperty
  a_ratio_stored: assert property (p_ratio_stored) else $error("ratio not stored");

  c_apply: cover property (@(posedge sys_clk) $fell(apply_busy));
  c_loop:  cover property (@(posedge sys_clk) mode_effective && system_clock_out[0]);
  c_align: cover property (@(posedge sys_clk) state_reg == PCD_HOLD && hold_mask != '0);
endmodule
`default_nettype wire

// File: core/pcd_divider.sv
/*
  One programmable clock divider: divide by ratio+1 (1..32), 50% duty,
  output registered. Toggles once every ratio+1 input edges.
  Assumes ref_tick marks each edge, rising and falling, of its input clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcd_divider
  import pcd_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire logic               ref_tick,
  input  wire logic               enable,
  input  wire logic               hold,
  input  wire logic               load_now,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    clk_out
);
  logic [RATIO_W-1:0] cnt_reg, cnt_next;
  logic [RATIO_W-1:0] act_reg, act_next;
  logic               out_reg, out_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    act_next = act_reg;
    out_next = out_reg;
    if (load_now)
      act_next = ratio;
    if (!enable || hold)
    begin
      // Parked low at end of period, so the first edge after release rises
      cnt_next = act_next;
      out_next = 1'b0;
    end
    else if (ref_tick)
    begin
      // Toggle every ratio+1 edges: exact half duty for odd ratios too
      if (cnt_reg >= act_reg)
      begin
        cnt_next = '0;
        out_next = ~out_reg;
      end
      else
        cnt_next = cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cnt_reg <= '0;
      act_reg <= RATIO_RST;
      out_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;

  property p_off_low;
    @(posedge sys_clk) disable iff (srst) !enable |=> !clk_out;
  endproperty
  a_off_low: assert property (p_off_low) else $error("disabled divider toggled");
endmodule
`default_nettype wire

// File: core/pcd_pkg.sv
/*
  Package for the clock divider controller: field widths, reset values
  and counts shared by the top module and the divider module.
  Assumes a single synchronous clock domain.
*/
package pcd_pkg;
  localparam int           NUM_SYS       = 16;
  localparam int           RATIO_W       = 5;
  localparam int           MULT_W        = 2;
  localparam logic [4:0]   RATIO_RST     = 5'h00;
  localparam logic [1:0]   MULT_RST      = 2'h0;
  localparam logic [15:0]  ENABLE_RST    = 16'hFFFF;
  localparam logic         PRE_EN_RST    = 1'b1;
  localparam logic         MODE_RST      = 1'b0;
  localparam logic         SRC_RST       = 1'b1;
  localparam logic         LRST_RST      = 1'b1;
  localparam logic [15:0]  ALIGN_RST     = 16'h0000;
  localparam logic [5:0]   HOLD_CYCLES   = 6'h20;

  typedef enum logic [1:0] {
    PCD_IDLE  = 2'b00,
    PCD_APPLY = 2'b01,
    PCD_HOLD  = 2'b10,
    PCD_DONE  = 2'b11
  } pcd_state_t;
endpackage

// File: tb/pll_clock_divider_controller_tb_top.sv
/*
  Bench for the clock divider controller: drives the control ports, makes
  a slow reference clock and checks routing, ratios, apply and status.
  Assumes the design package and modules are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module pll_clock_divider_controller_tb_top;
  import pcd_pkg::*;
  localparam int REF_HALF = 4;
  localparam int LIMIT    = 20000;
  logic                        sys_clk;
  logic                        srst;
  logic                        reference_clock_in;
  logic                        loop_mode_select;
  logic                        mode_select_source;
  logic                        loop_reset_ctl;
  logic [MULT_W-1:0]           loop_multiplier;
  logic [RATIO_W-1:0]          pre_divider;
  logic                        pre_divider_enable;
  logic [NUM_SYS-1:0]          div_wr;
  logic [RATIO_W-1:0]          div_wr_ratio;
  logic [NUM_SYS-1:0]          system_divider_enable;
  logic [NUM_SYS-1:0]          align_select_reg;
  logic                        apply_trigger;
  logic                        apply_busy;
  logic [NUM_SYS-1:0]          ratio_changed_reg;
  logic                        loop_in_reset;
  logic                        mode_effective;
  logic                        auxiliary_clock_out;
  logic [NUM_SYS-1:0]          system_clock_out;
  logic [16:0]                 mon;
  int                          mismatches;
  int                          checks_done;
  int                          cycles;
  int                          ref_cnt;

  assign mon = {auxiliary_clock_out, system_clock_out};

  pcd_controller i_pcd_controller (
    .sys_clk               (sys_clk),
    .srst                  (srst),
    .reference_clock_in    (reference_clock_in),
    .loop_mode_select      (loop_mode_select),
    .mode_select_source    (mode_select_source),
    .loop_reset_ctl        (loop_reset_ctl),
    .loop_multiplier       (loop_multiplier),
    .pre_divider           (pre_divider),
    .pre_divider_enable    (pre_divider_enable),
    .div_wr                (div_wr),
    .div_wr_ratio          (div_wr_ratio),
    .system_divider_enable (system_divider_enable),
    .align_select_reg      (align_select_reg),
    .apply_trigger         (apply_trigger),
    .apply_busy            (apply_busy),
    .ratio_changed_reg     (ratio_changed_reg),
    .loop_in_reset         (loop_in_reset),
    .mode_effective        (mode_effective),
    .auxiliary_clock_out   (auxiliary_clock_out),
    .system_clock_out      (system_clock_out)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Reference at one eighth of sys_clk
  always @(posedge sys_clk)
  begin
    #1;
    ref_cnt = (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    if (ref_cnt == 0)
      reference_clock_in = ~reference_clock_in;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_rise(input int idx);
    int n;
    n = 0;
    while (mon[idx] !== 1'b0 && n < 300)
    begin
      @(negedge sys_clk);
      n++;
    end
    while (mon[idx] !== 1'b1 && n < 600)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // Period and high time in sys_clk cycles
  task automatic measure(input int idx, output int per, output int hi);
    logic prv;
    wait_rise(idx);
    per = 0;
    hi = 1;
    prv = 1'b1;
    repeat (600)
    begin
      @(negedge sys_clk);
      per++;
      if (mon[idx] === 1'b1 && prv === 1'b0)
        break;
      if (mon[idx] === 1'b1)
        hi++;
      prv = mon[idx];
    end
  endtask

  task automatic rises(input int idx, input int ncyc, output int n);
    logic prv;
    prv = mon[idx];
    n = 0;
    repeat (ncyc)
    begin
      @(negedge sys_clk);
      if (mon[idx] === 1'b1 && prv === 1'b0)
        n++;
      prv = mon[idx];
    end
  endtask

  task automatic wr_div(input int idx, input logic [4:0] r);
    tick(1);
    div_wr = 16'h0001 << idx;
    div_wr_ratio = r;
    tick(1);
    div_wr = 16'h0000;
  endtask

  initial
  begin
    int   per, hi, n, r4;
    logic p3, p6;
    {srst, mode_select_source, loop_reset_ctl, pre_divider_enable} = 4'hF;
    {loop_mode_select, apply_trigger, reference_clock_in} = 3'h0;
    {loop_multiplier, pre_divider, div_wr, div_wr_ratio} = '0;
    system_divider_enable = 16'hFFFF;
    align_select_reg = 16'h0000;
    {mismatches, checks_done, cycles, ref_cnt} = '0;
    tick(20);
    srst = 1'b0;
    tick(1);
    check(apply_busy, 1'b0);
    check(ratio_changed_reg, 16'h0000);
    check(mode_effective, 1'b0);
    check(loop_in_reset, 1'b1);
    measure(16, per, hi);
    check(per, 8);
    check(hi, 4);
    for (int i = 0; i < 16; i++)
    begin
      measure(i, per, hi);
      check(per, 8);
    end
    tick(1);
    loop_mode_select = 1'b1;
    tick(8);
    check(mode_effective, 1'b0);
    loop_mode_select = 1'b0;
    system_divider_enable = 16'hFFFB;
    rises(2, 64, n);
    check(n, 0);
    tick(1);
    system_divider_enable = 16'hFFFF;
    wr_div(5, 5'h00);
    check(ratio_changed_reg, 16'h0000);
    wr_div(3, 5'h01);
    wr_div(6, 5'h03);
    wr_div(4, 5'h03);
    check(ratio_changed_reg, 16'h0058);
    measure(3, per, hi);
    check(per, 8);
    tick(1);
    align_select_reg = 16'h0048;
    apply_trigger = 1'b1;
    tick(1);
    apply_trigger = 1'b0;
    check(apply_busy, 1'b1);
    n = 1;
    hi = 0;
    r4 = 0;
    p3 = system_clock_out[4];
    for (int k = 1; k < 60; k++)
    begin
      tick(1);
      apply_trigger = (k == 10);
      if (apply_busy === 1'b1)
        n++;
      if (k >= 4 && k <= 32 && (system_clock_out[3] | system_clock_out[6]) !== 1'b0)
        hi++;
      if (k >= 2 && k <= 34 && system_clock_out[4] === 1'b1 && p3 === 1'b0)
        r4++;
      p3 = system_clock_out[4];
    end
    check(n, 35);
    check(hi, 0);
    check(r4 > 0, 1'b1);
    check(ratio_changed_reg, 16'h0000);
    hi = 0;
    p3 = mon[3];
    p6 = mon[6];
    for (int k = 0; k < 96; k++)
    begin
      @(negedge sys_clk);
      if (mon[6] === 1'b1 && p6 === 1'b0 && !(mon[3] === 1'b1 && p3 === 1'b0))
        hi++;
      p3 = mon[3];
      p6 = mon[6];
    end
    check(hi, 0);
    measure(3, per, hi);
    check(per, 16);
    check(hi, 8);
    measure(6, per, hi);
    check(per, 32);
    check(hi, 16);
    measure(4, per, hi);
    check(per, 32);
    tick(1);
    mode_select_source = 1'b0;
    tick(8 * REF_HALF);
    loop_reset_ctl = 1'b1;
    pre_divider = 5'h01;
    tick(16);
    loop_reset_ctl = 1'b0;
    tick(2);
    check(loop_in_reset, 1'b0);
    tick(32);
    loop_mode_select = 1'b1;
    tick(3);
    check(mode_effective, 1'b1);
    for (int m = 0; m < 4; m++)
    begin
      tick(1);
      loop_multiplier = m[1:0];
      tick(48);
      rises(3, 160, n);
      check(n >= 5 * m + 4 && n <= 5 * m + 6, 1'b1);
    end
    tick(1);
    loop_mode_select = 1'b0;
    tick(3);
    check(mode_effective, 1'b0);
    measure(0, per, hi);
    check(per, 8);
    finish_test();
  end
endmodule
`default_nettype wire
